// File: rtl/inline_security_pkg.sv
// Package with register map, field layout and reset values of the security control block.
package inline_security_pkg;
  localparam logic [5:0] security_control_main_addr = 6'h19;
  localparam logic [5:0] security_length_offsets_addr = 6'h1A;
  localparam int mode_lsb = 0;
  localparam int tag_code_lsb = 2;
  localparam int receive_key_bit = 5;
  localparam int transmit_key_bit = 6;
  localparam int standalone_key_bit = 7;
  localparam int prefix_sel_bit = 8;
  localparam int guard_en_bit = 9;
  localparam int receive_offset_lsb = 0;
  localparam int transmit_offset_lsb = 8;
  localparam logic [15:0] main_writable_mask = 16'h03FF;
  localparam logic [15:0] offsets_writable_mask = 16'h7F7F;
  localparam logic [15:0] main_reset_value = 16'h03C4;
  localparam logic [15:0] offsets_reset_value = 16'h0000;
  localparam logic [2:0] tag_code_reserved = 3'h0;

  typedef enum logic [1:0] {
    mode_off,
    mode_cbc_mac,
    mode_ctr,
    mode_ccm
  } protect_mode_e;

  typedef struct packed {
    logic receive_buffer_guard_en;
    logic mac_length_prefix_sel;
    logic standalone_key_choice;
    logic transmit_key_choice;
    logic receive_key_choice;
    logic [2:0] tag_length_code;
    protect_mode_e inline_protect_mode;
  } security_cfg_s;

  typedef struct packed {
    logic [6:0] transmit_clear_offset;
    logic [6:0] receive_clear_offset;
  } offsets_cfg_s;

  typedef struct packed {
    logic use_prefix;
    logic [4:0] tag_bytes;
    logic [6:0] tx_skip;
    logic [6:0] rx_skip;
  } engine_setup_s;
endpackage

// File: rtl/security_word_reg.sv
// One 16-bit configuration word with a write mask and reset value.
`timescale 1ns/1ns
module security_word_reg
  import inline_security_pkg::*;
#(
  parameter logic [15:0] reset_value = 16'h0000,
  parameter logic [15:0] writable_mask = 16'hFFFF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic write_en,
  input wire logic [15:0] write_data,
  output logic [15:0] word
);
  logic [15:0] word_reg;
  logic [15:0] word_next;

  always_comb begin
    word_next = word_reg;
    if (write_en) begin
      // Reserved positions are forced low so they always read back as zero.
      word_next = write_data & writable_mask; // [RL12]
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      word_reg <= reset_value;
    end else begin
      word_reg <= word_next;
    end
  end

  assign word = word_reg;
endmodule // security_word_reg

// File: rtl/inline_security_control.sv
// Security control register pair and the derived setup for the in-line cipher engine.
// Summary of operation
// [RL1] Mode field: off, CBC-MAC, CTR, CCM.
// [RL2] Tag length code equals (M-2)/2, reset 1.
// [RL3] Key bits choose key zero or one.
// [RL4] Prefix bit adds length byte before MAC.
// [RL5] Prefix bit ignored inside CCM mode.
// [RL6] Host sets prefix bit for frame MAC.
// [RL7] Host clears buffer guard when unused.
// [RL8] Transmit offset counts cleartext bytes before processing.
// [RL9] Receive offset counts cleartext bytes before processing.
// [RL10] Offsets ignored in stand-alone operations; reset zero. Code zeroes only the skips; the prefix byte still uses them.
// [RL11] Host writes zeros to reserved bits.
// [RL12] Fields read and write; reserved read zero.
`timescale 1ns/1ns
module inline_security_control
  import inline_security_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic standalone_op,
  input wire logic transmit_dir,
  input wire logic [6:0] packet_length,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  output security_cfg_s security_cfg,
  output offsets_cfg_s offsets_cfg,
  output engine_setup_s engine_setup,
  output logic [7:0] mac_prefix_byte,
  output logic [6:0] active_key_select,
  output logic tag_code_invalid
);
  logic [15:0] main_word;
  logic [15:0] offsets_word;
  logic main_we;
  logic offsets_we;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic hit_reg;
  logic hit_next;
  engine_setup_s setup_reg;
  engine_setup_s setup_next;
  logic [7:0] prefix_reg;
  logic [7:0] prefix_next;
  logic [6:0] key_reg;
  logic [6:0] key_next;
  logic invalid_reg;
  logic invalid_next;
  security_cfg_s cfg_reg;
  security_cfg_s cfg_next;
  offsets_cfg_s off_reg;
  offsets_cfg_s off_next;
  logic [6:0] tx_auth_length;

  // Reserved write bits are masked inside each word; the host is expected to send zeros.
  assign main_we = reg_write && (reg_addr == security_control_main_addr); // [RL11]
  assign offsets_we = reg_write && (reg_addr == security_length_offsets_addr);

  security_word_reg #(
    .reset_value(main_reset_value),
    .writable_mask(main_writable_mask)
  ) main_reg_inst (
    .mclk(mclk),
    .resetn(resetn),
    .write_en(main_we),
    .write_data(reg_wdata),
    .word(main_word)
  );

  security_word_reg #(
    .reset_value(offsets_reset_value),
    .writable_mask(offsets_writable_mask)
  ) offsets_reg_inst (
    .mclk(mclk),
    .resetn(resetn),
    .write_en(offsets_we),
    .write_data(reg_wdata),
    .word(offsets_word)
  );

  always_comb begin
    rdata_next = rdata_reg;
    hit_next = 1'b0;
    if (reg_read) begin
      hit_next = 1'b1;
      case (reg_addr)
        security_control_main_addr: begin
          rdata_next = main_word; // [RL12]
        end
        security_length_offsets_addr: begin
          rdata_next = offsets_word; // [RL12]
        end
        default: begin
          rdata_next = 16'h0000;
          hit_next = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    cfg_next.inline_protect_mode = protect_mode_e'(main_word[mode_lsb +: 2]); // [RL1]
    cfg_next.tag_length_code = main_word[tag_code_lsb +: 3]; // [RL2]
    cfg_next.receive_key_choice = main_word[receive_key_bit]; // [RL3]
    cfg_next.transmit_key_choice = main_word[transmit_key_bit]; // [RL3]
    cfg_next.standalone_key_choice = main_word[standalone_key_bit]; // [RL3]
    cfg_next.mac_length_prefix_sel = main_word[prefix_sel_bit];
    // The guard bit is kept as written; the host decides when to drop it.
    cfg_next.receive_buffer_guard_en = main_word[guard_en_bit]; // [RL7]
    off_next.transmit_clear_offset = offsets_word[transmit_offset_lsb +: 7]; // [RL8]
    off_next.receive_clear_offset = offsets_word[receive_offset_lsb +: 7]; // [RL9]
  end

  always_comb begin
    // A reserved code is flagged and not corrected; the engine is given 2 tag bytes for it, the formula value for code 0.
    case (cfg_next.tag_length_code)
      3'h1: begin
        setup_next.tag_bytes = 5'h04; // [RL2]
      end
      3'h2: begin
        setup_next.tag_bytes = 5'h06; // [RL2]
      end
      3'h3: begin
        setup_next.tag_bytes = 5'h08; // [RL2]
      end
      3'h4: begin
        setup_next.tag_bytes = 5'h0A; // [RL2]
      end
      3'h5: begin
        setup_next.tag_bytes = 5'h0C; // [RL2]
      end
      3'h6: begin
        setup_next.tag_bytes = 5'h0E; // [RL2]
      end
      3'h7: begin
        setup_next.tag_bytes = 5'h10; // [RL2]
      end
      default: begin
        setup_next.tag_bytes = 5'h02;
      end
    endcase
    invalid_next = (cfg_next.tag_length_code == tag_code_reserved); // [RL2]
    // Only CBC-MAC mode takes the prefix byte, with or without stand-alone operation; the CCM MAC stage never does.
    case (cfg_next.inline_protect_mode)
      mode_cbc_mac: begin
        setup_next.use_prefix = cfg_next.mac_length_prefix_sel; // [RL4] [RL6]
      end
      mode_ccm: begin
        setup_next.use_prefix = 1'b0; // [RL5]
      end
      default: begin
        setup_next.use_prefix = 1'b0;
      end
    endcase
    // A frame shorter than its offset plus two wraps modulo 128; the host must not set that up.
    tx_auth_length = packet_length - off_next.transmit_clear_offset - 7'h02; // [RL4]
    if (standalone_op) begin
      setup_next.tx_skip = 7'h00; // [RL10]
      setup_next.rx_skip = 7'h00; // [RL10]
    end else begin
      setup_next.tx_skip = off_next.transmit_clear_offset; // [RL8]
      setup_next.rx_skip = off_next.receive_clear_offset; // [RL9]
    end
    if (!setup_next.use_prefix) begin
      prefix_next = 8'h00;
    end else if (transmit_dir) begin
      prefix_next = {1'b0, tx_auth_length}; // [RL4]
    end else begin
      prefix_next = {1'b0, off_next.receive_clear_offset}; // [RL4]
    end
    key_next = {4'h0, cfg_next.standalone_key_choice, cfg_next.transmit_key_choice,
                cfg_next.receive_key_choice}; // [RL3]
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
      hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= security_cfg_s'(main_reset_value[9:0]);
      off_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
      off_reg <= off_next;
    end
  end

  // The derived setup reads zero in reset and shows the reset settings one edge after release.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      setup_reg <= '0;
      prefix_reg <= 8'h00;
      key_reg <= 7'h00;
      invalid_reg <= 1'b0;
    end else begin
      setup_reg <= setup_next;
      prefix_reg <= prefix_next;
      key_reg <= key_next;
      invalid_reg <= invalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit = hit_reg;
  assign security_cfg = cfg_reg;
  assign offsets_cfg = off_reg;
  assign engine_setup = setup_reg;
  assign mac_prefix_byte = prefix_reg;
  assign active_key_select = key_reg;
  assign tag_code_invalid = invalid_reg;
endmodule // inline_security_control

// File: verification/inline_security_sva.sv
// Port checker for the security control register pair.
`timescale 1ns/1ns
module inline_security_sva
  import inline_security_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic standalone_op,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit,
  input wire security_cfg_s security_cfg,
  input wire offsets_cfg_s offsets_cfg,
  input wire engine_setup_s engine_setup,
  input wire logic [7:0] mac_prefix_byte,
  input wire logic [6:0] active_key_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic mapped;
  assign mapped = reg_addr == security_control_main_addr ||
                  reg_addr == security_length_offsets_addr;
  chk_unmapped_read: assert property (
    reg_read && !mapped |=> reg_rdata == 16'h0000 && !reg_hit)
    else $error("unmapped read not refused");
  chk_hit_pulse: assert property (
    reg_read && mapped |=> reg_hit)
    else $error("read hit missing");
  chk_reserved_zero: assert property (
    reg_read && reg_addr == security_control_main_addr |=> reg_rdata[15:10] == 6'h00)
    else $error("reserved bits not zero");
  chk_cfg_write: assert property (
    reg_write && reg_addr == security_control_main_addr |->
    ##2 security_cfg == $past(reg_wdata[9:0], 2))
    else $error("main word not applied");
  chk_offs_write: assert property (
    reg_write && reg_addr == security_length_offsets_addr |->
    ##2 offsets_cfg == {$past(reg_wdata[14:8], 2), $past(reg_wdata[6:0], 2)})
    else $error("offsets not applied");
  chk_key_map: assert property (
    $past(resetn) |-> active_key_select == {4'h0, security_cfg.standalone_key_choice,
    security_cfg.transmit_key_choice, security_cfg.receive_key_choice})
    else $error("key select wrong");
  chk_tag_bytes: assert property (
    $past(resetn) |->
    engine_setup.tag_bytes == 5'({security_cfg.tag_length_code, 1'b0}) + 5'h02)
    else $error("tag length wrong");
  chk_no_prefix: assert property (
    $past(resetn) && security_cfg.inline_protect_mode != mode_cbc_mac |->
    !engine_setup.use_prefix && mac_prefix_byte == 8'h00)
    else $error("prefix outside mac mode");
  chk_standalone_skip: assert property (
    $past(standalone_op) |-> engine_setup.tx_skip == 7'h00 && engine_setup.rx_skip == 7'h00)
    else $error("skips not cleared");
  cover property (reg_write && reg_addr == security_control_main_addr);
  cover property (security_cfg.inline_protect_mode == mode_ccm && security_cfg.mac_length_prefix_sel);
  cover property (reg_read && !mapped);
  cover property (engine_setup.use_prefix && mac_prefix_byte != 8'h00);
endmodule // inline_security_sva

// File: verification/testbench.sv
// Self-checking bench for the security control register pair.
`timescale 1ns/1ns
module testbench;
  import inline_security_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic standalone_op = 1'b0;
  logic transmit_dir = 1'b0;
  logic [6:0] packet_length = 7'h00;
  logic [15:0] reg_rdata;
  logic reg_hit;
  security_cfg_s security_cfg;
  offsets_cfg_s offsets_cfg;
  engine_setup_s engine_setup;
  logic [7:0] mac_prefix_byte;
  logic [6:0] active_key_select;
  logic tag_code_invalid;
  logic [15:0] m_word = main_reset_value;
  logic [15:0] o_word = offsets_reset_value;
  logic [31:0] seed = 32'hE7FA;
  int n_errors = 0;
  int checked = 0;
  inline_security_control dut (.mclk(mclk), .resetn(resetn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .standalone_op(standalone_op), .transmit_dir(transmit_dir),
    .packet_length(packet_length), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .security_cfg(security_cfg), .offsets_cfg(offsets_cfg), .engine_setup(engine_setup),
    .mac_prefix_byte(mac_prefix_byte), .active_key_select(active_key_select),
    .tag_code_invalid(tag_code_invalid));
  initial begin
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  // The host sends zeros in reserved positions of both words.
  function automatic logic [15:0] legal_data(input logic [5:0] a, input logic [15:0] d);
    if (a == security_control_main_addr) return d & main_writable_mask;
    if (a == security_length_offsets_addr) return d & offsets_writable_mask;
    return d;
  endfunction
  function automatic logic prefix_on();
    return m_word[8] && m_word[1:0] == 2'h1;
  endfunction
  function automatic logic [19:0] exp_setup();
    logic [19:0] e;
    e = {prefix_on(), 5'({m_word[4:2], 1'b0}) + 5'h02, 14'h0000};
    if (!standalone_op) e[13:0] = {o_word[14:8], o_word[6:0]};
    return e;
  endfunction
  function automatic logic [19:0] exp_prefix();
    if (!prefix_on()) return 20'h00000;
    if (transmit_dir) return 20'(7'(packet_length - o_word[14:8] - 7'h02));
    return 20'(o_word[6:0]);
  endfunction
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d);
    logic [19:0] want;
    @(negedge mclk);
    reg_write = wr;
    reg_read = ~wr;
    reg_addr = a;
    reg_wdata = legal_data(a, d);
    @(negedge mclk);
    reg_write = 1'b0;
    reg_read = 1'b0;
    if (wr && a == 6'h19) m_word = d & main_writable_mask;
    if (wr && a == 6'h1A) o_word = d & offsets_writable_mask;
    want = a == 6'h19 ? 20'(m_word) : a == 6'h1A ? 20'(o_word) : 20'h00000;
    if (!wr) check(20'(reg_hit), 20'(a == 6'h19 || a == 6'h1A));
    if (!wr) check(20'(reg_rdata), want);
  endtask
  task automatic verify();
    repeat (3) @(negedge mclk);
    access(1'b0, 6'h19, 16'h0000);
    access(1'b0, 6'h1A, 16'h0000);
    access(1'b0, 6'h1C, 16'h0000);
    check(20'(security_cfg), 20'(m_word[9:0]));
    check(20'(offsets_cfg), 20'({o_word[14:8], o_word[6:0]}));
    check(20'(engine_setup), exp_setup());
    check(20'(mac_prefix_byte), exp_prefix());
    check(20'(active_key_select), 20'(m_word[7:5]));
    check(20'(tag_code_invalid), 20'(m_word[4:2] == 3'h0));
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    verify();
    $display("reset values test done");
    access(1'b1, 6'h19, 16'hFFE3);
    access(1'b1, 6'h1B, 16'hFFFF);
    verify();
    $display("ccm and reserved code test done");
    access(1'b1, 6'h19, 16'h0004);
    verify();
    access(1'b1, 6'h1A, 16'h0509);
    access(1'b1, 6'h19, 16'h0345);
    transmit_dir = 1'b1;
    packet_length = 7'h14;
    verify();
    standalone_op = 1'b1;
    transmit_dir = 1'b0;
    verify();
    $display("prefix and guard test done");
    repeat (60) begin
      seed = next_rand(seed);
      standalone_op = seed[20];
      transmit_dir = seed[21];
      packet_length = seed[28:22];
      access(1'b1, 6'h19 + 6'(seed[1:0]), seed[31:16] ^ seed[15:0]);
      verify();
    end
    $display("random test done");
    final_report();
  end
  initial begin
    // The tests need about 725 cycles; over four times that leaves ample margin.
    repeat (3200) @(posedge mclk);
    n_errors++;
    final_report();
  end
endmodule // testbench
bind inline_security_control inline_security_sva chk (.mclk(mclk), .resetn(resetn),
  .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .standalone_op(standalone_op), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .security_cfg(security_cfg), .offsets_cfg(offsets_cfg), .engine_setup(engine_setup),
  .mac_prefix_byte(mac_prefix_byte), .active_key_select(active_key_select));
